// ### logic/reg_access_pkg.sv
// Constants for the register-access bank: register indexes, field masks and reset values.
// Assumes a single synchronous host port on the block clock.
`default_nettype none
package reg_access_pkg;

   localparam int DataWidth = 32;
   localparam int AddrWidth = 4;
   localparam int FlagWidth = 8;
   localparam int DbCount = 3;

   // Register indexes on the host port.
   localparam logic [3:0] IdxCtrl = 4'h0;
   localparam logic [3:0] IdxStatus = 4'h1;
   localparam logic [3:0] IdxCmd = 4'h2;
   localparam logic [3:0] IdxEvent = 4'h3;
   localparam logic [3:0] IdxReq = 4'h4;
   localparam logic [3:0] IdxWrStat = 4'h5;
   localparam logic [3:0] IdxDbA = 4'h6;
   localparam logic [3:0] IdxDbB = 4'h7;
   localparam logic [3:0] IdxDbFree = 4'h8;
   localparam logic [3:0] IdxArm = 4'h9;

   // Control register layout: [15:0] read/write, [23:16] must_write_zero_bit field kept
   // as reserved, [31:24] preserve_contents_bit field kept as read/write storage.
   localparam logic [31:0] CtrlRwMask = 32'h0000_FFFF;
   localparam logic [31:0] CtrlZeroMask = 32'h00FF_0000;
   localparam logic [31:0] CtrlKeepMask = 32'hFF00_0000;
   localparam logic [31:0] CtrlStoreMask = CtrlRwMask | CtrlKeepMask;

   // Position of the first double-buffered register that the arming register controls.
   localparam int DbArmedFirst = 0;
   localparam int DbArmedLast = 1;

   localparam logic [31:0] CtrlReset = 32'h0000_0000;
   localparam logic [31:0] CmdReset = 32'h0000_0000;
   localparam logic [31:0] WrStatReset = 32'h0000_0000;
   localparam logic [31:0] DbReset = 32'h0000_0000;
   localparam logic [7:0] FlagReset = 8'h00;
   localparam logic [31:0] ReadZero = 32'h0000_0000;

endpackage
`default_nettype wire

// ### logic/db_stage.sv
// Two-stage double-buffered register: host writes land in the first stage, an update
// strobe moves them into the second stage that drives hardware.
// Assumes write and update strobes are one-cycle pulses on mclk.
`timescale 1ns/1ns
`default_nettype none
module db_stage
   import reg_access_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Host side
   input wire logic wrEn,
   input wire logic [31:0] wrData,
   // Update strobe
   input wire logic takeUpdate,
   // Stages
   output logic [31:0] firstStage,
   output logic [31:0] secondStage
);

   typedef struct packed {
      logic [31:0] first;
      logic [31:0] second;
   } db_state_t;

   db_state_t state_reg;
   db_state_t state_next;

   always_comb
   begin
      state_next = state_reg;
      // A write in the update cycle still loses to the old first stage in the copy;
      // the new value waits for the following update point.
      if (takeUpdate)
         state_next.second = state_reg.first; // R10
      if (wrEn)
         state_next.first = wrData; // R9
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg.first <= DbReset;
         state_reg.second <= DbReset;
      end
      else
         state_reg <= state_next;
   end

   assign firstStage = state_reg.first;
   assign secondStage = state_reg.second;

endmodule
`default_nettype wire

// ### logic/reg_access_bank.sv
// Register bank that shows every bit access class on one host read/write port.
// Assumes host strobes, status inputs, events and the update point are all on mclk.
//
// Functional notes
// R1: A read/write bit stores what is written, drives hardware from it and reads it back.
// R2: A reserved bit ignores writes and reads as zero.
// R3: Software writes zero to a must-write-zero bit, which may be reserved or read/write.
// R4: Software writes back the read value of a preserve-contents bit, which may be stored.
// R5: A read-only bit ignores writes and reads a hardware status source.
// R6: A write-only bit stores and drives hardware but always reads as zero.
// R7: A write-one-to-clear bit is set by hardware events and cleared by a software one.
// R8: A write-one-to-set bit is set by a software one and cleared by hardware events.
// R9: A double-buffered register holds writes in a first stage until its update point.
// R10: At the update point the first stage moves to the live stage; reads show the first.
// R11: Armed registers update only after an arming write, all together at the next point.
// R12: A write to an armed register before the update point disarms the group.
// R13: A write/read-status register drives hardware from writes but reads hardware status.
// R14: A hardware set and a software clear of one sticky bit in the same cycle leave it set.
`timescale 1ns/1ns
`default_nettype none
module reg_access_bank
   import reg_access_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Host port
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [3:0] addr,
   input wire logic [31:0] wrData,
   output logic [31:0] rdData,
   output logic rdValid,
   // Hardware status and events
   input wire logic [31:0] statusIn,
   input wire logic [31:0] wrStatusIn,
   input wire logic [7:0] eventSet,
   input wire logic [7:0] reqClear,
   input wire logic updatePoint,
   // Hardware controls
   output logic [31:0] ctrlOut,
   output logic [31:0] cmdOut,
   output logic [31:0] wrStatCtrlOut,
   output logic [7:0] eventFlags,
   output logic [7:0] reqFlags,
   output logic armedOut,
   output logic [31:0] dbLiveA,
   output logic [31:0] dbLiveB,
   output logic [31:0] dbLiveFree
);

   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] cmd;
      logic [31:0] wrStat;
      logic [7:0] events;
      logic [7:0] reqs;
      logic armed;
      logic [31:0] rdData;
      logic rdValid;
   } bank_state_t;

   bank_state_t state_reg;
   bank_state_t state_next;

   logic [DbCount-1:0] dbWr;
   logic [DbCount-1:0] dbUpdate;
   logic [31:0] dbFirst [DbCount];
   logic [31:0] dbSecond [DbCount];
   logic armedWrite;
   logic armedUpdate;

   assign dbWr[0] = wrEn && (addr == IdxDbA);
   assign dbWr[1] = wrEn && (addr == IdxDbB);
   assign dbWr[2] = wrEn && (addr == IdxDbFree);
   assign armedWrite = dbWr[0] || dbWr[1];
   // A disarming write in the update cycle blocks the copy so the group never tears.
   assign armedUpdate = updatePoint && state_reg.armed && !armedWrite; // R11 R12

   genvar gi;
   generate
      for (gi = 0; gi < DbCount; gi++)
      begin : g_db
         if (gi >= DbArmedFirst && gi <= DbArmedLast)
         begin : g_armed
            assign dbUpdate[gi] = armedUpdate; // R11
         end
         else
         begin : g_free
            assign dbUpdate[gi] = updatePoint; // R9
         end
         db_stage u_stage (
            .mclk(mclk),
            .rstn(rstn),
            .wrEn(dbWr[gi]),
            .wrData(wrData),
            .takeUpdate(dbUpdate[gi]),
            .firstStage(dbFirst[gi]),
            .secondStage(dbSecond[gi])
         );
      end
   endgenerate

   always_comb
   begin
      state_next = state_reg;
      state_next.rdValid = rdEn;

      // Event flags: hardware term is applied after the software term so it wins.
      if (wrEn && addr == IdxEvent)
         state_next.events = state_reg.events & ~wrData[7:0]; // R7
      state_next.events = state_next.events | eventSet; // R7 R14
      // A request write and a completion in one cycle keep the request, so it is not lost.
      state_next.reqs = state_reg.reqs & ~reqClear; // R8
      if (wrEn && addr == IdxReq)
         state_next.reqs = state_next.reqs | wrData[7:0]; // R8

      if (armedUpdate)
         state_next.armed = 1'b0;
      if (armedWrite && state_reg.armed)
         state_next.armed = 1'b0; // R12
      if (wrEn && addr == IdxArm)
         state_next.armed = 1'b1; // R11

      if (wrEn)
      begin
         case (addr)
            IdxCtrl: state_next.ctrl = wrData & CtrlStoreMask; // R1 R2 R3 R4
            IdxCmd: state_next.cmd = wrData; // R6
            IdxWrStat: state_next.wrStat = wrData; // R13
            default: state_next.ctrl = state_reg.ctrl; // R5
         endcase
      end

      state_next.rdData = ReadZero;
      if (rdEn)
      begin
         case (addr)
            IdxCtrl: state_next.rdData = state_reg.ctrl; // R1 R2
            IdxStatus: state_next.rdData = statusIn; // R5
            IdxCmd: state_next.rdData = ReadZero; // R6
            IdxEvent: state_next.rdData = {24'h000000, state_reg.events}; // R7
            IdxReq: state_next.rdData = {24'h000000, state_reg.reqs}; // R8
            IdxWrStat: state_next.rdData = wrStatusIn; // R13
            IdxDbA: state_next.rdData = dbFirst[0]; // R10
            IdxDbB: state_next.rdData = dbFirst[1]; // R10
            IdxDbFree: state_next.rdData = dbFirst[2]; // R10
            IdxArm: state_next.rdData = {31'h00000000, state_reg.armed};
            default: state_next.rdData = ReadZero; // R2
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg.ctrl <= CtrlReset;
         state_reg.cmd <= CmdReset;
         state_reg.wrStat <= WrStatReset;
         state_reg.events <= FlagReset;
         state_reg.reqs <= FlagReset;
         state_reg.armed <= 1'b0;
         state_reg.rdData <= ReadZero;
         state_reg.rdValid <= 1'b0;
      end
      else
         state_reg <= state_next;
   end

   assign rdData = state_reg.rdData;
   assign rdValid = state_reg.rdValid;
   assign ctrlOut = state_reg.ctrl; // R1
   assign cmdOut = state_reg.cmd; // R6
   assign wrStatCtrlOut = state_reg.wrStat; // R13
   assign eventFlags = state_reg.events;
   assign reqFlags = state_reg.reqs;
   assign armedOut = state_reg.armed;
   assign dbLiveA = dbSecond[0]; // R10
   assign dbLiveB = dbSecond[1];
   assign dbLiveFree = dbSecond[2];

endmodule
`default_nettype wire

// ### verification/reg_access_checker.sv
// Checker for the register bank: access classes, sticky flags and arming.
// Assumes it is bound to reg_access_bank and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module reg_access_checker
   import reg_access_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Host port
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [3:0] addr,
   input wire logic [31:0] wrData,
   input wire logic [31:0] rdData,
   // Hardware side
   input wire logic [31:0] statusIn,
   input wire logic [7:0] eventSet,
   input wire logic [7:0] reqClear,
   input wire logic updatePoint,
   input wire logic [31:0] ctrlOut,
   input wire logic [31:0] wrStatCtrlOut,
   input wire logic [7:0] eventFlags,
   input wire logic [7:0] reqFlags,
   input wire logic armedOut,
   input wire logic [31:0] dbLiveA
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic [7:0] clrMask;
   logic [7:0] setMask;
   logic dbWrite;
   assign clrMask = (wrEn && addr == IdxEvent) ? wrData[7:0] : 8'h00;
   assign setMask = (wrEn && addr == IdxReq) ? wrData[7:0] : 8'h00;
   assign dbWrite = wrEn && (addr == IdxDbA || addr == IdxDbB);
   property p_ctrl;
      wrEn && addr == IdxCtrl |=> ctrlOut == ($past(wrData) & CtrlStoreMask);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control value not stored");
   property p_resv;
      rdEn && addr == IdxCtrl |=> rdData[23:16] == 8'h00;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
   property p_ro;
      rdEn && addr == IdxStatus |=> rdData == $past(statusIn);
   endproperty
   a_ro: assert property (p_ro) else $error("status read wrong");
   property p_wo;
      rdEn && addr == IdxCmd |=> rdData == 32'h0000_0000;
   endproperty
   a_wo: assert property (p_wo) else $error("command read nonzero");
   property p_w1c;
      1'b1 |=> eventFlags == (($past(eventFlags) & ~$past(clrMask)) | $past(eventSet));
   endproperty
   a_w1c: assert property (p_w1c) else $error("event flags wrong");
   property p_w1s;
      1'b1 |=> reqFlags == (($past(reqFlags) & ~$past(reqClear)) | $past(setMask));
   endproperty
   a_w1s: assert property (p_w1s) else $error("request flags wrong");
   property p_noarm;
      updatePoint && !armedOut |=> $stable(dbLiveA);
   endproperty
   a_noarm: assert property (p_noarm) else $error("unarmed group updated");
   property p_disarm;
      armedOut && dbWrite |=> !armedOut;
   endproperty
   a_disarm: assert property (p_disarm) else $error("group stayed armed");
   property p_wrstat;
      wrEn && addr == IdxWrStat |=> wrStatCtrlOut == $past(wrData);
   endproperty
   a_wrstat: assert property (p_wrstat) else $error("write status control wrong");
   c_update: cover property (armedOut && updatePoint);
   c_race: cover property (|(eventSet & clrMask));
   c_disarm: cover property (armedOut && dbWrite);
endmodule
bind reg_access_bank reg_access_checker chk_u (.mclk, .rstn, .wrEn, .rdEn, .addr, .wrData,
   .rdData, .statusIn, .eventSet, .reqClear, .updatePoint, .ctrlOut, .wrStatCtrlOut,
   .eventFlags, .reqFlags, .armedOut, .dbLiveA);
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the register bank, one task per scenario.
// Assumes the bank and its checker are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
module testbench
   import reg_access_pkg::*;
;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic wrEn = 1'b0;
   logic rdEn = 1'b0;
   logic updatePoint = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wrData = 32'h0, statusIn = 32'h0, wrStatusIn = 32'h0;
   logic [7:0] eventSet = 8'h0, reqClear = 8'h0, eventFlags, reqFlags;
   logic [31:0] rdData, ctrlOut, cmdOut, wrStatCtrlOut, dbLiveA, dbLiveB, dbLiveFree;
   logic rdValid, armedOut;
   int miscompares = 0;
   int checks = 0;
   reg_access_bank dut_u (.mclk, .rstn, .wrEn, .rdEn, .addr, .wrData, .rdData, .rdValid,
      .statusIn, .wrStatusIn, .eventSet, .reqClear, .updatePoint, .ctrlOut, .cmdOut,
      .wrStatCtrlOut, .eventFlags, .reqFlags, .armedOut, .dbLiveA, .dbLiveB, .dbLiveFree);
   initial forever #4 mclk = ~mclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Every op writes; index F is unmapped, so it doubles as a cycle with no write.
   task automatic op(input logic [3:0] a, input logic [31:0] d, input logic [7:0] ev,
      input logic [7:0] cl, input logic up);
      @(posedge mclk);
      #1 {wrEn, addr, wrData, eventSet, reqClear, updatePoint} = {1'b1, a, d, ev, cl, up};
      @(posedge mclk);
      #1 {wrEn, eventSet, reqClear, updatePoint} = '0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge mclk);
      #1 {rdEn, addr} = {1'b1, a};
      @(posedge mclk);
      #1 rdEn = 1'b0;
      chk(rdData, exp);
      chk({31'h0, rdValid}, 32'h0000_0001);
   endtask
   task automatic t_plain;
      op(IdxCtrl, 32'hA500_1234, '0, '0, '0);
      chk(ctrlOut, 32'hA500_1234);
      rd(IdxCtrl, 32'hA500_1234);
      op(IdxCtrl, 32'hA500_0055, '0, '0, '0);
      chk(ctrlOut, 32'hA500_0055);
      statusIn = 32'h1357_9BDF;
      op(IdxStatus, 32'hFFFF_FFFF, '0, '0, '0);
      rd(IdxStatus, 32'h1357_9BDF);
      op(IdxCmd, 32'hCAFE_0001, '0, '0, '0);
      chk(cmdOut, 32'hCAFE_0001);
      rd(IdxCmd, 32'h0);
      wrStatusIn = 32'h0000_00A5;
      op(IdxWrStat, 32'h1111_2222, '0, '0, '0);
      chk(wrStatCtrlOut, 32'h1111_2222);
      rd(IdxWrStat, 32'h0000_00A5);
      op(4'hC, 32'hFFFF_FFFF, '0, '0, '0);
      rd(4'hC, 32'h0);
      $display("test plain done");
   endtask
   task automatic t_flags;
      op(4'hF, 32'h0, 8'h81, '0, '0);
      rd(IdxEvent, 32'h0000_0081);
      op(IdxEvent, 32'h0000_0001, 8'h01, '0, '0);
      chk({24'h0, eventFlags}, 32'h0000_0081);
      op(IdxEvent, 32'h0000_0080, '0, '0, '0);
      chk({24'h0, eventFlags}, 32'h0000_0001);
      op(IdxReq, 32'h0000_000F, 8'h00, 8'h03, '0);
      chk({24'h0, reqFlags}, 32'h0000_000F);
      op(4'hF, 32'h0, '0, 8'h03, '0);
      rd(IdxReq, 32'h0000_000C);
      $display("test flags done");
   endtask
   task automatic t_dbuf;
      op(IdxDbFree, 32'h0000_BEEF, '0, '0, '0);
      chk(dbLiveFree, 32'h0);
      rd(IdxDbFree, 32'h0000_BEEF);
      op(4'hF, 32'h0, '0, '0, 1'b1);
      chk(dbLiveFree, 32'h0000_BEEF);
      op(IdxDbA, 32'h0000_AAAA, '0, '0, '0);
      op(IdxDbB, 32'h0000_BBBB, '0, '0, 1'b1);
      op(4'hF, 32'h0, '0, '0, 1'b1);
      chk(dbLiveA, 32'h0);
      op(IdxArm, 32'h0, '0, '0, '0);
      chk({31'h0, armedOut}, 32'h0000_0001);
      op(IdxDbB, 32'h0000_B0B0, '0, '0, '0);
      chk({31'h0, armedOut}, 32'h0000_0000);
      op(4'hF, 32'h0, '0, '0, 1'b1);
      chk(dbLiveB, 32'h0);
      rd(IdxDbB, 32'h0000_B0B0);
      op(IdxArm, 32'h0, '0, '0, '0);
      rd(IdxArm, 32'h0000_0001);
      op(4'hF, 32'h0, '0, '0, 1'b1);
      chk(dbLiveA, 32'h0000_AAAA);
      chk(dbLiveB, 32'h0000_B0B0);
      chk({31'h0, armedOut}, 32'h0000_0000);
      $display("test dbuf done");
   endtask
   task automatic results;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge mclk);
      #1 rstn = 1'b1;
      t_plain();
      t_flags();
      t_dbuf();
      results();
   end
   // About 65 cycles of traffic; the limit leaves ample margin.
   initial
   begin
      #20000;
      miscompares++;
      results();
   end
endmodule
`default_nettype wire
